// ---- closed_loop_motor_config.sv ----
// Closed-loop setup register bank and the logic that applies its fields.
// Assumes a classic Wishbone master on ref_clk and an algorithm on the same clock.
//
// Summary of operation
// [R1] Decel rate bits 23:19, 1Fh unlimited
// [R2] Decel field used only surge off, source zero
// [R3] Source select one decelerates at accel rate
// [R4] Bits 18:15 set 10..75 kHz carrier
// [R5] Bit 14 picks continuous or discontinuous modulation
// [R6] Bits 13:12 choose loops producing speed pulse
// [R7] Bits 11:8 divide speed pulse, 0/1 equal
// [R8] Bit 7 extends pulse until back-EMF low
// [R9] Bits 6:4 pick back-EMF floor 1..30 mV
// [R10] Bit 0 picks recirculation low-speed stop action
// [R11] Recirculation is stop method code one
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module closed_loop_motor_config (
   // Clock and reset
   input  wire logic                            ref_clk,
   input  wire logic                            arst_n,
   // Wishbone slave
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [7:0]                      wb_adr_i,
   input  wire logic [31:0]                     wb_dat_i,
   input  wire logic [3:0]                      wb_sel_i,
   output logic [31:0]                          wb_dat_o,
   output logic                                 wb_ack_o,
   // Algorithm state
   input  wire motor_cfg_pkg::motion_state_type motion,
   input  wire logic                            elec_edge,
   input  wire logic [7:0]                      backemf_mv,
   // Applied settings
   output motor_cfg_pkg::decel_cmd_type         decel_cmd,
   output logic [4:0]                           closed_loop_accel_rate,
   output logic                                 svm_discontinuous,
   output logic                                 overmod_enable,
   output logic                                 deadtime_comp_enable,
   output logic                                 velocity_loop_off,
   output logic [motor_cfg_pkg::PERIOD_W-1:0]   carrier_period,
   output logic                                 carrier_tick,
   output logic                                 speed_pulse_output,
   output logic [2:0]                           stop_action
);
   localparam int PW = motor_cfg_pkg::PERIOD_W;

   // One-hot bus states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_type;

   // Bus side
   bus_state_type             bus_state_reg;
   bus_state_type             bus_state_next;
   motor_cfg_pkg::wb_req_type req;

   // Register storage
   logic [31:0]               cfg_reg;
   logic [31:0]               cfg_next;
   logic [2:0]                stop_reg;
   logic [2:0]                stop_next;
   logic [31:0]               rd_next;
   logic [31:0]               status_word;

   // Request decode
   logic                      take;
   logic                      hit_cfg;
   logic                      hit_stop;
   logic                      hit_status;

   // Decoded fields
   logic [4:0]                decel_field;
   logic [4:0]                accel_field;
   logic                      decel_src;
   logic                      surge_guard_enable;
   logic [3:0]                freq_field;
   logic [1:0]                when_field;
   logic [3:0]                div_field;
   logic                      span_field;
   logic [2:0]                floor_field;
   logic                      low_stop_field;

   // Applied settings
   logic [3:0]                freq_code_reg;
   logic [PW-1:0]             period_tab [0:15];
   motor_cfg_pkg::decel_cmd_type decel_next;
   logic                      loop_allows;
   logic                      floor_valid;
   logic [7:0]                floor_mv;
   logic                      above_floor;
   logic                      pulse_enable;
   logic [2:0]                stop_action_next;

   // Address decode, used for both reads and writes
   // Bits 1:0 are ignored
   function automatic logic is_at(input logic [7:0] adr, input logic [7:0] off);
      is_at = (adr[7:2] == off[7:2]);
   endfunction

   // Bus request bundle and decode
   assign req        = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i};
   assign take       = wb_cyc_i && wb_stb_i && (bus_state_reg == BUS_IDLE);
   assign hit_cfg    = is_at(req.adr, motor_cfg_pkg::CFG_OFFSET);
   assign hit_stop   = is_at(req.adr, motor_cfg_pkg::STOP_OFFSET);
   assign hit_status = is_at(req.adr, motor_cfg_pkg::STATUS_OFFSET);

   // Byte-lane write merge for the setup word
   // Unselected lanes keep their bytes
   generate
      for (genvar b = 0; b < 4; b++)
      begin : g_lane
         assign cfg_next[8*b+7:8*b] = (take && req.we && hit_cfg && req.sel[b]) ?
                                      req.dat[8*b+7:8*b] : cfg_reg[8*b+7:8*b];
      end
   endgenerate

   // Stop method sits in lane 0 only
   // Upper bits read back as zero
   assign stop_next = (take && req.we && hit_stop && req.sel[0]) ? req.dat[2:0] : stop_reg;

   // Read mux; unmapped offsets answer with zero
   // Status: code, stop action, pulse
   assign status_word = {16'h0000, freq_code_reg, 5'h00, stop_action,
                         2'b00, pulse_enable, speed_pulse_output};
   assign rd_next = hit_cfg    ? cfg_reg :
                    hit_stop   ? {29'h0, stop_reg} :
                    hit_status ? status_word : 32'h0000_0000;

   // One wait state: ack the cycle after the strobe, then drop it
   // No second take in the ack cycle
   assign bus_state_next = take ? BUS_ACK : BUS_IDLE;

   // Bus slave state and registers
   // Writes land at the take edge
   // Read data is zero outside ack
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bus_state_reg <= BUS_IDLE;
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h0000_0000;
         cfg_reg       <= motor_cfg_pkg::CFG_RESET;
         stop_reg      <= motor_cfg_pkg::STOP_RESET;
      end
      else
      begin
         bus_state_reg <= bus_state_next;
         wb_ack_o      <= take;
         wb_dat_o      <= take ? rd_next : 32'h0000_0000;
         cfg_reg       <= cfg_next;
         stop_reg      <= stop_next;
      end
   end

   // Field extraction
   // Parity bit 31 is stored, unused
   assign decel_field        = cfg_reg[motor_cfg_pkg::DEC_MSB:motor_cfg_pkg::DEC_LSB];
   assign accel_field        = cfg_reg[motor_cfg_pkg::ACC_MSB:motor_cfg_pkg::ACC_LSB];
   assign decel_src          = cfg_reg[motor_cfg_pkg::DSRC_BIT];
   assign surge_guard_enable = cfg_reg[motor_cfg_pkg::SURGE_BIT];
   assign freq_field         = cfg_reg[motor_cfg_pkg::FREQ_MSB:motor_cfg_pkg::FREQ_LSB];
   assign when_field         = cfg_reg[motor_cfg_pkg::WHEN_MSB:motor_cfg_pkg::WHEN_LSB];
   assign div_field          = cfg_reg[motor_cfg_pkg::DIV_MSB:motor_cfg_pkg::DIV_LSB];
   assign span_field         = cfg_reg[motor_cfg_pkg::SPAN_BIT];
   assign floor_field        = cfg_reg[motor_cfg_pkg::FLOOR_MSB:motor_cfg_pkg::FLOOR_LSB];
   assign low_stop_field     = cfg_reg[motor_cfg_pkg::LOWSTOP_BIT];

   // Plain pass-through settings
   // [R5] modulation style select
   assign svm_discontinuous      = cfg_reg[motor_cfg_pkg::MODE_BIT];

   // Used by the algorithm as is
   assign overmod_enable         = cfg_reg[motor_cfg_pkg::OVM_BIT];
   assign deadtime_comp_enable   = cfg_reg[motor_cfg_pkg::DTCOMP_BIT];
   assign velocity_loop_off      = cfg_reg[motor_cfg_pkg::VLOOP_BIT];
   assign closed_loop_accel_rate = accel_field;

   // Deceleration source selection
   // [R2] field only with surge off
   assign decel_next.limit_on   = !surge_guard_enable;

   // [R3] source one takes accel rate
   assign decel_next.from_accel = decel_src;
   assign decel_next.rate_code  = decel_src ? accel_field : decel_field;

   // [R1] code 1Fh lifts the limit
   assign decel_next.unlimited  = (decel_next.rate_code == motor_cfg_pkg::DECEL_NO_LIMIT);

   // Carrier period per code, computed at elaboration
   // Divide rounds down, carrier a touch fast
   generate
      for (genvar c = 0; c < 16; c++)
      begin : g_period
         localparam int unsigned KHZ = motor_cfg_pkg::FREQ_BASE_KHZ +
                                       motor_cfg_pkg::FREQ_STEP_KHZ * c;
         assign period_tab[c] = PW'(motor_cfg_pkg::CLK_KHZ / KHZ);
      end
   endgenerate

   // [R4] carrier from frequency field
   // Codes Eh and Fh keep the last usable rate rather than stall the bridge
   // Latched code shows in status
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         freq_code_reg <= 4'h0;
      end
      else if (freq_field <= motor_cfg_pkg::FREQ_LAST_CODE)
      begin
         freq_code_reg <= freq_field;
      end
   end

   // Carrier period registered for the timer and outside
   // Reset value is the code 0 period
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         carrier_period <= PW'(motor_cfg_pkg::CLK_KHZ / motor_cfg_pkg::FREQ_BASE_KHZ);
      end
      else
      begin
         carrier_period <= period_tab[freq_code_reg];
      end
   end

   // Switching period marks
   // New period taken at next wrap
   pwm_carrier_timer #(
      .W (PW)
   ) u_carrier (
      .ref_clk      (ref_clk),
      .arst_n       (arst_n),
      .period       (carrier_period),
      .carrier_tick (carrier_tick)
   );

   // [R6] loop phases that allow the pulse
   // Code 2: open loop only on the first try, closed loop always
   // Code 3 keeps the pulse off
   assign loop_allows = (when_field == motor_cfg_pkg::WHEN_BOTH)
                           ? (motion.open_loop || motion.closed_loop) :
                        (when_field == motor_cfg_pkg::WHEN_CLOSED)
                           ? motion.closed_loop :
                        (when_field == motor_cfg_pkg::WHEN_FIRST_TRY)
                           ? (motion.closed_loop ||
                              (motion.open_loop && motion.first_attempt)) :
                        1'b0;

   // [R9] back-EMF floor lookup
   // Codes 6 and 7 have no floor, so coasting never holds the pulse
   // Magnitude only, sign folded upstream
   assign floor_valid = (floor_field <= motor_cfg_pkg::FLOOR_LAST_CODE);
   assign floor_mv    = floor_valid ? motor_cfg_pkg::FLOOR_MV[floor_field] : 8'hff;
   assign above_floor = floor_valid && (backemf_mv >= floor_mv);

   // [R8] active span: driven, or coasting above floor
   assign pulse_enable = loop_allows &&
                         (motion.driven || (span_field && above_floor));

   // Clears while disabled, starts in phase
   // [R7] divide by pole-pair code
   speed_pulse_div u_pulse (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .enable    (pulse_enable),
      .divide    (div_field),
      .elec_edge (elec_edge),
      .pulse_out (speed_pulse_output)
   );

   // Other cases pass the method through
   // [R11] recirculation is stop code one
   // [R10] low-speed choice in align or open loop
   assign stop_action_next = ((stop_reg == motor_cfg_pkg::STOP_RECIRC) &&
                              (motion.align || motion.open_loop))
                              ? (low_stop_field ? motor_cfg_pkg::STOP_LOW
                                                : motor_cfg_pkg::STOP_HIZ)
                              : stop_reg;

   // Registered commands to the algorithm
   // One cycle behind the register
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         decel_cmd   <= '0;
         stop_action <= motor_cfg_pkg::STOP_HIZ;
      end
      else
      begin
         decel_cmd   <= decel_next;
         stop_action <= stop_action_next;
      end
   end
endmodule // closed_loop_motor_config

// ---- closed_loop_motor_config_tb.sv ----
// Self-checking bench of the closed-loop setup bank.
// Assumes the checker binds itself; the bench is the bus master.
`timescale 1ns/1ps
module closed_loop_motor_config_tb;
   // Design ports
   logic                                 ref_clk = 1'b0;
   logic                                 arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]                           wb_adr_i, backemf_mv;
   logic [31:0]                          wb_dat_i, wb_dat_o;
   logic [3:0]                           wb_sel_i;
   logic                                 elec_edge, carrier_tick, speed_pulse_output;
   logic                                 svm_discontinuous, overmod_enable;
   logic                                 deadtime_comp_enable, velocity_loop_off;
   logic [4:0]                           closed_loop_accel_rate;
   logic [2:0]                           stop_action;
   logic [motor_cfg_pkg::PERIOD_W-1:0]   carrier_period;
   motor_cfg_pkg::motion_state_type      motion;
   motor_cfg_pkg::decel_cmd_type         decel_cmd;
   // Bench state
   int                                   failures = 0, checked = 0, seed = 80, n;
   logic [31:0]                          rd, cfg, d;
   logic [31:0]                          corner [4] = '{32'h00f8_0000, 32'h3f00_0000,
                                                        32'h00f8_0008, 32'h0600_0000};
   logic [3:0]                           codes [5] = '{4'h0, 4'h2, 4'h3, 4'h6, 4'h8};
   logic [3:0]                           divs [4] = '{4'h0, 4'h1, 4'h3, 4'hf};

   closed_loop_motor_config u_closed_loop_motor_config (.ref_clk, .arst_n, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .motion,
      .elec_edge, .backemf_mv, .decel_cmd, .closed_loop_accel_rate, .svm_discontinuous,
      .overmod_enable, .deadtime_comp_enable, .velocity_loop_off, .carrier_period,
      .carrier_tick, .speed_pulse_output, .stop_action);

   // 40 MHz core clock
   always #12.5 ref_clk = ~ref_clk;

   // Expected decel command: source, rate and no-limit code
   function automatic logic [31:0] decel_of(input logic [31:0] c);
      logic [4:0] r;
      r = c[24] ? c[29:25] : c[23:19];
      return {24'h0, 1'b1, c[24], r == 5'h1f, r};
   endfunction

   // Recirculation in slow phases resolves to hi-z or low side
   function automatic logic [31:0] stop_of(input logic [2:0] m, input logic b, input logic oa);
      if (m == motor_cfg_pkg::STOP_RECIRC && oa)
         return b ? 32'(motor_cfg_pkg::STOP_LOW) : 32'(motor_cfg_pkg::STOP_HIZ);
      return 32'(m);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One classic cycle, held until ack is seen
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                     input logic [3:0] s);
      int k;
      k = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= dt;
      wb_sel_i <= s;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (wb_ack_o !== 1'b1 && k < 20);
      if (wb_ack_o !== 1'b1)
         failures++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Settings path takes three edges; sample on the falling edge
   task automatic settle();
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic drive(input logic [4:0] mo, input logic [7:0] b);
      @(posedge ref_clk);
      motion     <= mo;
      backemf_mv <= b;
   endtask

   task automatic pulses(input int k);
      repeat (k)
      begin
         @(posedge ref_clk);
         elec_edge <= 1'b1;
         @(posedge ref_clk);
         elec_edge <= 1'b0;
      end
      settle();
   endtask

   // Hang guard well beyond the expected run
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      failures++;
      final_report();
   end

   initial
   begin
      {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, elec_edge} = 5'h0;
      {wb_adr_i, backemf_mv, wb_dat_i, wb_sel_i, motion} = 57'h0;
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      check(32'(carrier_period), 32'hfa0);
      wb(1'b0, 8'h88, 32'h0, 4'hf);
      check(rd, 32'h0);
      wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
      wb(1'b0, 8'h40, 32'h0, 4'hf);
      check(rd, 32'h0);
      $display("reset and unmapped done");
      // Corner and random settings, last one with two lanes only
      cfg = 32'h0;
      for (int i = 0; i < 12; i++)
      begin
         d = (i < 4) ? corner[i] : $random(seed);
         wb(1'b1, 8'h88, d, (i == 11) ? 4'h5 : 4'hf);
         cfg = (i == 11) ? {cfg[31:24], d[23:16], cfg[15:8], d[7:0]} : d;
         wb(1'b0, 8'h88, 32'h0, 4'hf);
         check(rd, cfg);
         settle();
         check(32'(svm_discontinuous), 32'(cfg[14]));
         check(32'(closed_loop_accel_rate), 32'(cfg[29:25]));
         check({overmod_enable, deadtime_comp_enable, velocity_loop_off}, {cfg[30], cfg[2:1]});
         if (cfg[3])
            check(32'(decel_cmd.limit_on), 32'h0);
         else
            check(32'(decel_cmd), decel_of(cfg));
      end
      $display("settings done");
      // Switching frequency codes; Eh keeps the last valid period
      foreach (codes[j])
      begin
         wb(1'b1, 8'h88, 32'(codes[j]) << 15, 4'hf);
         settle();
         check(32'(carrier_period), 32'(40000 / (10 + 5 * codes[j])));
      end
      wb(1'b1, 8'h88, 32'h0007_0000, 4'hf);
      settle();
      check(32'(carrier_period), 32'h320);
      repeat (2)
      begin
         n = 0;
         @(negedge ref_clk);
         while (carrier_tick !== 1'b1 && n < 9000)
         begin
            @(negedge ref_clk);
            n++;
         end
      end
      check(32'(n + 1), 32'h320);
      wb(1'b0, 8'h90, 32'h0, 4'hf);
      check(rd, 32'h0000_8000);
      $display("frequency done");
      // Stop codes 0..5 against each stop-bit, in align and in closed loop
      for (int m = 0; m < 6; m++)
         for (int k = 0; k < 4; k++)
         begin
            wb(1'b1, 8'h88, 32'(k[0]), 4'hf);
            wb(1'b1, 8'h8c, 32'(m), 4'hf);
            drive(k[1] ? 5'h08 : 5'h02, 8'h00);
            settle();
            check(32'(stop_action), stop_of(3'(m), k[0], k[1]));
         end
      wb(1'b0, 8'h8c, 32'h0, 4'hf);
      check(rd, 32'h5);
      $display("stop done");
      // Divider: high after N edges, low after 2N
      foreach (divs[j])
      begin
         drive(5'h00, 8'h00);
         wb(1'b1, 8'h88, 32'(divs[j]) << 8, 4'hf);
         settle();
         check(32'(speed_pulse_output), 32'h0);
         n = (divs[j] < 4'h2) ? 1 : int'(divs[j]);
         drive(5'h12, 8'h00);
         pulses(n - 1);
         check(32'(speed_pulse_output), 32'h0);
         pulses(1);
         check(32'(speed_pulse_output), 32'h1);
         pulses(n);
         check(32'(speed_pulse_output), 32'h0);
      end
      // When codes: closed only, first try, not applicable
      wb(1'b1, 8'h88, 32'h1000, 4'hf);
      drive(5'h14, 8'h00);
      pulses(1);
      check(32'(speed_pulse_output), 32'h0);
      wb(1'b1, 8'h88, 32'h2000, 4'hf);
      drive(5'h15, 8'h00);
      pulses(1);
      check(32'(speed_pulse_output), 32'h1);
      drive(5'h14, 8'h00);
      settle();
      check(32'(speed_pulse_output), 32'h0);
      wb(1'b1, 8'h88, 32'h3000, 4'hf);
      drive(5'h12, 8'h00);
      pulses(1);
      check(32'(speed_pulse_output), 32'h0);
      // Back-EMF extension at the 5 mV floor, then a floor not applicable
      wb(1'b1, 8'h88, 32'h00a0, 4'hf);
      drive(5'h02, 8'h05);
      pulses(1);
      check(32'(speed_pulse_output), 32'h1);
      drive(5'h02, 8'h04);
      settle();
      check(32'(speed_pulse_output), 32'h0);
      wb(1'b1, 8'h88, 32'h00e0, 4'hf);
      drive(5'h02, 8'hff);
      pulses(1);
      check(32'(speed_pulse_output), 32'h0);
      $display("speed pulse done");
      final_report();
   end
endmodule // closed_loop_motor_config_tb

// ---- motor_cfg_pkg.sv ----
// Constants, field layout and bus and algorithm types of the closed-loop motor setup bank.
// Assumes one 40 MHz core clock; the bus side is a classic Wishbone slave.
package motor_cfg_pkg;

   // Core clock rate
   localparam int unsigned CLK_KHZ = 40000;

   // Byte offsets on the register bus
   localparam logic [7:0] CFG_OFFSET    = 8'h88;
   localparam logic [7:0] STOP_OFFSET   = 8'h8c;
   localparam logic [7:0] STATUS_OFFSET = 8'h90;

   // Reset values
   localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
   localparam logic [2:0]  STOP_RESET = 3'h0;

   // Field positions of closed_loop_settings_one
   localparam int ACC_MSB      = 29;
   localparam int ACC_LSB      = 25;
   localparam int OVM_BIT      = 30;
   localparam int DSRC_BIT     = 24;
   localparam int DEC_MSB      = 23;
   localparam int DEC_LSB      = 19;
   localparam int FREQ_MSB     = 18;
   localparam int FREQ_LSB     = 15;
   localparam int MODE_BIT     = 14;
   localparam int WHEN_MSB     = 13;
   localparam int WHEN_LSB     = 12;
   localparam int DIV_MSB      = 11;
   localparam int DIV_LSB      = 8;
   localparam int SPAN_BIT     = 7;
   localparam int FLOOR_MSB    = 6;
   localparam int FLOOR_LSB    = 4;
   localparam int SURGE_BIT    = 3;
   localparam int DTCOMP_BIT   = 2;
   localparam int VLOOP_BIT    = 1;
   localparam int LOWSTOP_BIT  = 0;

   // Field codes
   localparam logic [4:0] DECEL_NO_LIMIT  = 5'h1f;
   localparam int unsigned FREQ_BASE_KHZ  = 10;
   localparam int unsigned FREQ_STEP_KHZ  = 5;
   localparam logic [3:0] FREQ_LAST_CODE  = 4'hd;
   localparam logic [1:0] WHEN_BOTH       = 2'h0;
   localparam logic [1:0] WHEN_CLOSED     = 2'h1;
   localparam logic [1:0] WHEN_FIRST_TRY  = 2'h2;
   localparam logic [2:0] FLOOR_LAST_CODE = 3'h5;
   localparam logic [3:0] DIV_ONE         = 4'h1;

   // Back-EMF floor in mV for codes 0..5
   localparam logic [7:0] FLOOR_MV [0:5] = '{8'h01, 8'h02, 8'h05, 8'h0a, 8'h14, 8'h1e};

   // Motor stop method codes
   localparam logic [2:0] STOP_HIZ    = 3'h0;
   localparam logic [2:0] STOP_RECIRC = 3'h1;
   localparam logic [2:0] STOP_LOW    = 3'h2;

   // Carrier period counter width (10 kHz needs 4000 cycles)
   localparam int PERIOD_W = 12;

   // One bus request as sampled
   typedef struct packed {
      logic [7:0]  adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
   } wb_req_type;

   // Motor phase reported by the control algorithm
   typedef struct packed {
      logic driven;
      logic align;
      logic open_loop;
      logic closed_loop;
      logic first_attempt;
   } motion_state_type;

   // Deceleration command handed to the speed ramp
   typedef struct packed {
      logic       limit_on;
      logic       from_accel;
      logic       unlimited;
      logic [4:0] rate_code;
   } decel_cmd_type;

endpackage

// ---- motor_cfg_props.sv ----
// Port checks for the closed-loop setup bank, one clock domain.
// Assumes the bind below and the package of the design.
`timescale 1ns/1ps
module motor_cfg_props (
   // Clock and reset
   input wire logic                                ref_clk,
   input wire logic                                arst_n,
   // Bus
   input wire logic                                wb_cyc_i,
   input wire logic                                wb_stb_i,
   input wire logic [31:0]                         wb_dat_o,
   input wire logic                                wb_ack_o,
   // Algorithm side
   input wire motor_cfg_pkg::motion_state_type     motion,
   input wire logic                                elec_edge,
   input wire logic [7:0]                          backemf_mv,
   input wire motor_cfg_pkg::decel_cmd_type        decel_cmd,
   input wire logic [4:0]                          closed_loop_accel_rate,
   input wire logic [motor_cfg_pkg::PERIOD_W-1:0]  carrier_period,
   input wire logic                                speed_pulse_output,
   input wire logic [2:0]                          stop_action
);
   // Single domain, so clock and reset are stated once
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   // Bus handshake shape
   ack_after_req_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
      else $error("no ack after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data off ack");
   // Accel output leads decel by one cycle, so wait until it is stable
   accel_source_a: assert property (decel_cmd.from_accel && $stable(closed_loop_accel_rate)
      |-> decel_cmd.rate_code == closed_loop_accel_rate) else $error("wrong decel source");
   no_limit_code_a: assert property (decel_cmd.limit_on && !decel_cmd.from_accel
      |-> decel_cmd.unlimited == (decel_cmd.rate_code == motor_cfg_pkg::DECEL_NO_LIMIT))
      else $error("unlimited flag wrong");
   period_range_a: assert property (carrier_period >= 12'h215 && carrier_period <= 12'hfa0)
      else $error("carrier period out of range");
   recirc_stop_a: assert property ((motion.align || motion.open_loop) [*2]
      |-> stop_action != motor_cfg_pkg::STOP_RECIRC) else $error("recirculation left in slow run");
   pulse_edge_a: assert property ($rose(speed_pulse_output) |-> $past(elec_edge))
      else $error("pulse rose without edge");
   pulse_idle_a: assert property ((!motion.driven && backemf_mv == 8'h00) [*2]
      |-> !speed_pulse_output) else $error("pulse active while idle");
endmodule // motor_cfg_props

bind closed_loop_motor_config motor_cfg_props u_motor_cfg_props (.ref_clk, .arst_n,
   .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .motion, .elec_edge, .backemf_mv,
   .decel_cmd, .closed_loop_accel_rate, .carrier_period, .speed_pulse_output, .stop_action);

// ---- pwm_carrier_timer.sv ----
// Free-running carrier counter that marks the start of every switching period.
// Assumes the period input comes from logic on the same clock.
`timescale 1ns/1ps
module pwm_carrier_timer #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         arst_n,
   // Period in core cycles
   input  wire logic [W-1:0] period,
   // One-cycle mark at period start
   output logic              carrier_tick
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic         wrap;

   // New period only taken at the wrap, so no runt period appears
   assign wrap       = (count_reg == '0);
   assign count_next = wrap ? period - W'(1) : count_reg - W'(1);

   // Down counter and tick
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_reg    <= '0;
         carrier_tick <= 1'b0;
      end
      else
      begin
         count_reg    <= count_next;
         carrier_tick <= wrap;
      end
   end
endmodule // pwm_carrier_timer

// ---- speed_pulse_div.sv ----
// Divides the electrical half-cycle marks down to the speed pulse square wave.
// Assumes elec_edge is a one-cycle mark from logic on the same clock.
`timescale 1ns/1ps
module speed_pulse_div (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   // Control
   input  wire logic       enable,
   input  wire logic [3:0] divide,
   input  wire logic       elec_edge,
   // Divided square wave
   output logic            pulse_out
);
   logic [3:0] count_reg;
   logic [3:0] last;
   logic       roll;

   // Codes 0 and 1 both divide by one
   assign last = (divide <= motor_cfg_pkg::DIV_ONE) ? 4'h0 : divide - 4'h1;
   assign roll = elec_edge && (count_reg >= last);

   // Toggle every divide edges; held low and cleared while disabled
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_reg <= 4'h0;
         pulse_out <= 1'b0;
      end
      else if (!enable)
      begin
         count_reg <= 4'h0;
         pulse_out <= 1'b0;
      end
      else if (roll)
      begin
         count_reg <= 4'h0;
         pulse_out <= !pulse_out;
      end
      else if (elec_edge)
      begin
         count_reg <= count_reg + 4'h1;
      end
   end
endmodule // speed_pulse_div
